// ==== src/data_bank_nvm_ctrl.sv ====
// Purpose: Page select register and nonvolatile array control on the data space bus.
// Assumes: CPU end drives one-cycle strobes; 128-byte array held here.
// Notes: RAM and LCD pages are routed out through pageMap only.
`timescale 1ns/1ps
`include "nvm_bank_defs.svh"
// Operation
// - Write-only page select register picks paged window.
// - Page bits: nvm 0,1; ram 3,4; lcd 5,6.
// - Addresses 00h-3Fh go to selected page.
// - Reset leaves page select register unchanged.
// - Software writes page select with whole bytes.
// - Software sets at most one page bit.
// - Page select survives interrupts and calls.
// - Standby disables array; accesses undefined.
// - Idle array reads like ordinary data.
// - Writes without program enable never program.
// - Busy during programming; accesses aborted meanwhile.
// - Control writes ignored while busy.
// - Byte mode programs addressed byte directly.
// - Entering row mode clears eight row latches.
// - Row address latched on first write.
// - Software never reads array in row mode.
// - Row start programs only loaded bytes.
// - Row mode and start clear after programming.
// - Start accepted only with enable and row mode.
// - Leaving row mode abandons loaded row.
// - Control resets zero; reserved bits kept clear.
// - Software keeps shadow copy for interrupt writes.
module data_bank_nvm_ctrl import nvm_bank_pkg::*; #(
  parameter logic [15:0] PROG_CYCLES = `NVM_PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  data_bus_if.dev bus,
  output logic [7:0] pageMap,
  output logic nvmBusy,
  output logic nvmStandby,
  output logic accessError
);
  dev_state_t q;
  dev_state_t d;
  logic [7:0] pageSel_q;
  logic [7:0] pageSel_d;
  logic [7:0] mem [0:127];
  logic memByteWr;
  logic memRowWr;
  logic paged;
  logic nvmSel;
  logic multiSel;
  logic [6:0] nvmIndex;
  logic [2:0] col;

  // ----------------------------------------------------------------------
  // Ports
  // ----------------------------------------------------------------------
  assign pageMap = q.pageOut;
  assign nvmBusy = q.busy;
  assign nvmStandby = q.standby;
  assign accessError = q.err;
  assign bus.rdata = q.rdata;
  assign bus.rvalid = q.rvalid;

  // ----------------------------------------------------------------------
  // Paged window decode
  // ----------------------------------------------------------------------
  assign paged = bus.addr < `PAGED_LIMIT;
  assign multiSel = (pageSel_q & (pageSel_q - 8'h01)) != 8'h00;
  assign nvmSel = q.pageWritten && !multiSel &&
                  (pageSel_q[`NVM_PAGE0_SEL_BIT] || pageSel_q[`NVM_PAGE1_SEL_BIT]);
  assign nvmIndex = {pageSel_q[`NVM_PAGE1_SEL_BIT], bus.addr[5:0]};
  assign col = bus.addr[2:0];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    pageSel_d = pageSel_q;
    memByteWr = 1'b0;
    memRowWr = 1'b0;
    d.rvalid = 1'b0;
    d.err = 1'b0;
    if (bus.wr && bus.addr == `PAGE_SELECT_ADDR) begin
      pageSel_d = bus.wdata & `PAGE_SELECT_USED;
      d.pageWritten = 1'b1;
    end
    d.pageOut = d.pageWritten ? pageSel_d : 8'h00;
    if (q.busy) begin
      if (q.cnt == 16'h0001) begin
        d.busy = 1'b0;
        if (q.doRow) begin
          memRowWr = 1'b1;
          d.rowMode = 1'b0;
          d.rowStart = 1'b0;
          d.rowLatched = 1'b0;
          d.rowValid = 8'h00;
        end else begin
          memByteWr = 1'b1;
        end
        d.doRow = 1'b0;
      end
      d.cnt = q.cnt - 16'h0001;
    end
    if (bus.wr && bus.addr == `NVM_CONTROL_ADDR && !q.busy) begin
      d.standby = bus.wdata[`NVM_STANDBY_BIT];
      d.progEn = bus.wdata[`NVM_PROG_ENABLE_BIT];
      d.rowMode = bus.wdata[`ROW_MODE_ENABLE_BIT];
      if (bus.wdata[`ROW_MODE_ENABLE_BIT] && !q.rowMode) begin
        d.rowValid = 8'h00;
        d.rowData = 64'h0;
        d.rowLatched = 1'b0;
      end
      if (!bus.wdata[`ROW_MODE_ENABLE_BIT]) begin
        d.rowValid = 8'h00;
        d.rowLatched = 1'b0;
        d.rowData = 64'h0;
      end
      if (bus.wdata[`ROW_PROG_START_BIT] && bus.wdata[`NVM_PROG_ENABLE_BIT] &&
          bus.wdata[`ROW_MODE_ENABLE_BIT] && q.rowMode) begin
        d.rowStart = 1'b1;
        d.busy = 1'b1;
        d.doRow = 1'b1;
        d.cnt = PROG_CYCLES;
      end
    end
    if (bus.wr && paged && nvmSel) begin
      if (q.standby || q.busy) begin
        d.err = 1'b1;
      end else if (q.rowMode) begin
        if (q.rowLatched && q.rowAddr != nvmIndex[6:3]) begin
          d.err = 1'b1;
        end else begin
          d.rowAddr = nvmIndex[6:3];
          d.rowLatched = 1'b1;
          d.rowValid[col] = 1'b1;
          d.rowData[{col, 3'b000} +: 8] = bus.wdata;
        end
      end else if (q.progEn) begin
        d.byteAddr = nvmIndex;
        d.byteData = bus.wdata;
        d.busy = 1'b1;
        d.doRow = 1'b0;
        d.cnt = PROG_CYCLES;
      end
    end
    if ((bus.wr || bus.rd) && paged && q.pageWritten && multiSel) begin
      d.err = 1'b1;
    end
    if (bus.rd) begin
      d.rvalid = 1'b1;
      d.rdata = 8'h00;
      if (bus.addr == `NVM_CONTROL_ADDR) begin
        d.rdata[`NVM_BUSY_BIT] = q.busy;
      end else if (paged && nvmSel) begin
        if (q.standby || q.busy) begin
          d.err = 1'b1;
        end else begin
          d.rdata = mem[nvmIndex];
          if (q.rowMode && q.rowLatched && q.rowAddr != nvmIndex[6:3]) begin
            d.err = 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Page select register, kept through reset
  // ----------------------------------------------------------------------
  // Software must write it before the first paged access.
  always_ff @(posedge clk) begin
    if (clkEn) begin
      pageSel_q <= pageSel_d;
    end
  end

  // ----------------------------------------------------------------------
  // Nonvolatile array
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (memByteWr) begin
        mem[q.byteAddr] <= q.byteData;
      end
      if (memRowWr) begin
        for (int i = 0; i < 8; i++) begin
          if (q.rowValid[i]) begin
            mem[{q.rowAddr, i[2:0]}] <= q.rowData[i * 8 +: 8];
          end
        end
      end
    end
  end
endmodule

// ==== src/nvm_bank_defs.svh ====
`ifndef NVM_BANK_DEFS_SVH
`define NVM_BANK_DEFS_SVH
// Purpose: Offsets, field positions, reset values and counts of the paged data block.
// Assumes: 8-bit data space addresses, 32-bit AXI4-Lite words on the controller side.
// Notes: Definitions only.

// ----------------------------------------------------------------------
// Data space map
// ----------------------------------------------------------------------
`define PAGE_SELECT_ADDR 8'hcb
`define NVM_CONTROL_ADDR 8'hdf
`define PAGED_LIMIT 8'h40
`define NVM_CONTROL_RESET 8'h00

// ----------------------------------------------------------------------
// Page select fields
// ----------------------------------------------------------------------
`define NVM_PAGE0_SEL_BIT 0
`define NVM_PAGE1_SEL_BIT 1
`define RAM_PAGE1_SEL_BIT 3
`define RAM_PAGE2_SEL_BIT 4
`define LCD_PAGE2_SEL_BIT 5
`define LCD_PAGE1_SEL_BIT 6
`define PAGE_SELECT_USED 8'h7b

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define NVM_PROG_ENABLE_BIT 0
`define NVM_BUSY_BIT 1
`define ROW_MODE_ENABLE_BIT 2
`define ROW_PROG_START_BIT 3
`define NVM_STANDBY_BIT 6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define NVM_PROG_CYCLES 16'h0400

// ----------------------------------------------------------------------
// Controller registers (AXI4-Lite byte addresses)
// ----------------------------------------------------------------------
`define CMD_REG_ADDR 4'h0
`define STATUS_REG_ADDR 4'h4
`define CMD_READ_BIT 16
`define STATUS_DONE_BIT 8
`define STATUS_PENDING_BIT 9
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ==== src/nvm_bank_pkg.sv ====
// Purpose: Types shared by both ends of the paged data block.
// Assumes: Constants come from nvm_bank_defs.svh.
// Notes: State records of both ends.
package nvm_bank_pkg;

  typedef struct packed {
    logic pageWritten;
    logic [7:0] pageOut;
    logic standby;
    logic progEn;
    logic rowMode;
    logic rowStart;
    logic busy;
    logic doRow;
    logic [15:0] cnt;
    logic [6:0] byteAddr;
    logic [7:0] byteData;
    logic [3:0] rowAddr;
    logic rowLatched;
    logic [7:0] rowValid;
    logic [63:0] rowData;
    logic [7:0] rdata;
    logic rvalid;
    logic err;
  } dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_WAIT
  } host_phase_t;

  typedef struct packed {
    host_phase_t phase;
    logic awTaken;
    logic wTaken;
    logic [3:0] awAddr;
    logic [31:0] wData;
    logic wFull;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [7:0] busAddr;
    logic [7:0] busWdata;
    logic busWr;
    logic busRd;
    logic [7:0] lastRdata;
    logic done;
  } host_state_t;

endpackage

// ==== src/data_bus_if.sv ====
// Purpose: Internal data space bus between the CPU core end and the paged block.
// Assumes: One clock; strobes are one-cycle pulses.
// Notes: Read data returns one cycle after the read strobe with rvalid.
`timescale 1ns/1ps
interface data_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rvalid;

  modport cpu (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
endinterface

// ==== src/cpu_access_ctrl.sv ====
// Purpose: CPU core end; turns AXI4-Lite commands into data space accesses.
// Assumes: AXI4-Lite on the same clock as the data bus.
// Notes: One data space access at a time; a command while one is pending is dropped.
`timescale 1ns/1ps
`include "nvm_bank_defs.svh"
module cpu_access_ctrl import nvm_bank_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  data_bus_if.cpu bus,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  host_state_t q;
  host_state_t d;

  // ----------------------------------------------------------------------
  // Ports
  // ----------------------------------------------------------------------
  assign awready = !q.awTaken && !q.bvalid;
  assign wready = !q.wTaken && !q.bvalid;
  assign arready = !q.rvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = `AXI_OKAY;
  assign bus.addr = q.busAddr;
  assign bus.wdata = q.busWdata;
  assign bus.wr = q.busWr;
  assign bus.rd = q.busRd;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.busWr = 1'b0;
    d.busRd = 1'b0;
    if (awvalid && awready) begin
      d.awTaken = 1'b1;
      d.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      d.wTaken = 1'b1;
      d.wData = wdata;
      d.wFull = wstrb[2:0] == 3'b111;
    end
    if (q.awTaken && q.wTaken) begin
      d.awTaken = 1'b0;
      d.wTaken = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `AXI_OKAY;
      if (q.awAddr != `CMD_REG_ADDR) begin
        d.bresp = `AXI_SLVERR;
      end else if (q.phase == HOST_IDLE && q.wFull) begin
        d.busAddr = q.wData[7:0];
        d.busWdata = q.wData[15:8];
        d.done = 1'b0;
        if (q.wData[`CMD_READ_BIT]) begin
          d.busRd = 1'b1;
          d.phase = HOST_WAIT;
        end else begin
          d.busWr = 1'b1;
          d.done = 1'b1;
        end
      end
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    case (q.phase)
      HOST_IDLE: begin
      end
      HOST_WAIT: begin
        if (bus.rvalid) begin
          d.lastRdata = bus.rdata;
          d.done = 1'b1;
          d.phase = HOST_IDLE;
        end
      end
      default: begin
        d.phase = HOST_IDLE;
      end
    endcase
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rdata = 32'h0;
      if (araddr == `STATUS_REG_ADDR) begin
        d.rdata[7:0] = q.lastRdata;
        d.rdata[`STATUS_DONE_BIT] = q.done;
        d.rdata[`STATUS_PENDING_BIT] = q.phase == HOST_WAIT;
      end else if (araddr == `CMD_REG_ADDR) begin
        d.rdata[15:0] = {q.busWdata, q.busAddr};
      end
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end
endmodule

// ==== bench/nvm_bank_assertions.sv ====
// Purpose: Data bus and status checks for the paged block pair.
// Assumes: One clock; PROG_CYCLES equals the device setting.
// Notes: Instantiated beside the interface.
`timescale 1ns/1ps
`include "nvm_bank_defs.svh"
module nvm_bank_assertions import nvm_bank_pkg::*; #(
  parameter logic [15:0] PROG_CYCLES = `NVM_PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [7:0] pageMap,
  input wire logic nvmBusy,
  input wire logic nvmStandby,
  input wire logic accessError
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [15:0] busyLen_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busyLen_q <= 16'h0000;
    end else begin
      busyLen_q <= nvmBusy ? busyLen_q + 16'h0001 : 16'h0000;
    end
  end
  sequence ctrlRead;
    rd && addr == `NVM_CONTROL_ADDR;
  endsequence
  sequence arrayHeld;
    (rd || wr) && addr < `PAGED_LIMIT && pageMap[1:0] != 2'b00 && (nvmBusy || nvmStandby);
  endsequence
  a_read_answer: assert property (rd |=> rvalid)
    else $error("read strobe not answered");
  a_valid_cause: assert property (rvalid |-> $past(rd))
    else $error("read valid without strobe");
  a_rdata_holds: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved without valid");
  a_ctrl_readback: assert property (ctrlRead |=> rdata == {6'h00, $past(nvmBusy), 1'b0})
    else $error("control readback wrong");
  a_page_hidden: assert property (rd && addr == `PAGE_SELECT_ADDR |=> rdata == 8'h00)
    else $error("page select readable");
  a_page_map: assert property (wr && addr == `PAGE_SELECT_ADDR |=> pageMap == ($past(wdata) & `PAGE_SELECT_USED))
    else $error("page map not loaded");
  a_busy_abort: assert property (arrayHeld |=> accessError)
    else $error("array access not aborted");
  a_busy_start: assert property ($rose(nvmBusy) |-> $past(wr))
    else $error("busy without write");
  a_busy_length: assert property ($fell(nvmBusy) |-> $past(busyLen_q) == PROG_CYCLES - 16'h0001)
    else $error("busy length wrong");
  a_ctrl_frozen: assert property (wr && addr == `NVM_CONTROL_ADDR && nvmBusy |=> $stable(nvmStandby))
    else $error("control changed while busy");
  a_standby_set: assert property (wr && addr == `NVM_CONTROL_ADDR && !nvmBusy
      |=> nvmStandby == $past(wdata[`NVM_STANDBY_BIT]))
    else $error("standby not loaded");
endmodule

// ==== bench/data_bank_select_and_eeprom_ctrl_tb.sv ====
// Purpose: Self-checking bench for the CPU end and paged block pair.
// Assumes: 125 MHz clock and a short programming window.
// Notes: Data space accesses go through the command register.
`timescale 1ns/1ps
`include "nvm_bank_defs.svh"
module data_bank_select_and_eeprom_ctrl_tb import nvm_bank_pkg::*; ;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam logic [15:0] PROG = 16'h0040;
  localparam logic [7:0] CTL = `NVM_CONTROL_ADDR;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, nvmBusy, nvmStandby, accessError;
  logic [1:0] bresp, rresp;
  logic [7:0] pageMap;
  int numErrors = 0, nTests = 0;
  int errCount = 0;
  data_bus_if busIf();
  always #4 clk = ~clk;
  always @(negedge clk) begin
    if (accessError === 1'b1) begin
      errCount++;
    end
  end
  cpu_access_ctrl cpu_access_ctrl_inst (.clk(clk), .rstn(rstn), .clkEn(1'b1), .bus(busIf.cpu),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  data_bank_nvm_ctrl #(.PROG_CYCLES(PROG)) data_bank_nvm_ctrl_inst (.clk(clk), .rstn(rstn), .clkEn(1'b1),
    .bus(busIf.dev), .pageMap(pageMap), .nvmBusy(nvmBusy), .nvmStandby(nvmStandby), .accessError(accessError));
  nvm_bank_assertions #(.PROG_CYCLES(PROG)) nvm_bank_assertions_inst (.clk(clk), .rstn(rstn),
    .addr(busIf.addr), .wdata(busIf.wdata), .wr(busIf.wr), .rd(busIf.rd), .rdata(busIf.rdata),
    .rvalid(busIf.rvalid), .pageMap(pageMap), .nvmBusy(nvmBusy), .nvmStandby(nvmStandby),
    .accessError(accessError));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic testDone();
    $display("Checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rready <= 1'b0;
  endtask
  task automatic dbWrite(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axiWrite(`CMD_REG_ADDR, {16'h0000, d, a}, r);
  endtask
  task automatic dbRead(input logic [7:0] a, output logic [7:0] d);
    logic [1:0] r;
    logic [31:0] s;
    axiWrite(`CMD_REG_ADDR, {15'h0000, 1'b1, 8'h00, a}, r);
    do axiRead(`STATUS_REG_ADDR, s); while (!s[`STATUS_DONE_BIT] || s[`STATUS_PENDING_BIT]);
    d = s[7:0];
  endtask
  task automatic waitIdle();
    repeat (2) @(posedge clk);
    while (nvmBusy) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic pageSelTest();
    logic [7:0] codes [7] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40, 8'h00};
    logic [7:0] d;
    logic [7:0] shadow;
    foreach (codes[i]) begin
      shadow = codes[i];
      dbWrite(`PAGE_SELECT_ADDR, shadow);
      repeat (2) @(posedge clk);
      check(pageMap, shadow);
    end
    dbRead(`PAGE_SELECT_ADDR, d);
    check(d, 8'h00);
  endtask
  task automatic byteTest();
    logic [7:0] d;
    dbWrite(CTL, 8'h01);
    dbWrite(`PAGE_SELECT_ADDR, 8'h01);
    dbWrite(8'h05, 8'ha5);
    dbRead(CTL, d);
    check(d, 8'h02);
    dbRead(8'h05, d);
    check(d, 8'h00);
    check(8'(errCount), 8'h01);
    dbWrite(CTL, 8'h40);
    waitIdle();
    check({7'h00, nvmStandby}, 8'h00);
    dbRead(8'h05, d);
    check(d, 8'ha5);
    dbWrite(CTL, 8'h00);
    dbWrite(8'h05, 8'h3c);
    repeat (4) @(posedge clk);
    check({7'h00, nvmBusy}, 8'h00);
    dbRead(8'h05, d);
    check(d, 8'ha5);
  endtask
  task automatic rowTest();
    logic [7:0] exp [4] = '{8'h01, 8'h77, 8'h02, 8'h03};
    logic [7:0] d;
    dbWrite(CTL, 8'h01);
    dbWrite(8'h19, 8'h77);
    waitIdle();
    dbWrite(CTL, 8'h05);
    dbWrite(8'h18, 8'h01);
    dbWrite(8'h1a, 8'h02);
    dbWrite(8'h1b, 8'h03);
    dbWrite(CTL, 8'h0d);
    waitIdle();
    foreach (exp[i]) begin
      dbRead(8'h18 + 8'(i), d);
      check(d, exp[i]);
    end
    dbWrite(CTL, 8'h0d);
    dbWrite(CTL, 8'h04);
    dbWrite(CTL, 8'h0c);
    repeat (4) @(posedge clk);
    check({7'h00, nvmBusy}, 8'h00);
    dbWrite(CTL, 8'h05);
    dbWrite(8'h18, 8'hff);
    dbWrite(CTL, 8'h01);
    dbWrite(CTL, 8'h05);
    dbWrite(8'h1a, 8'h55);
    dbWrite(8'h21, 8'h99);
    repeat (2) @(posedge clk);
    check(8'(errCount), 8'h02);
    dbWrite(CTL, 8'h0d);
    waitIdle();
    dbRead(8'h18, d);
    check(d, 8'h01);
    dbRead(8'h1a, d);
    check(d, 8'h55);
  endtask
  task automatic standbyTest();
    logic [7:0] d;
    logic [1:0] r;
    logic [31:0] s;
    dbWrite(CTL, 8'h40);
    repeat (2) @(posedge clk);
    check({7'h00, nvmStandby}, 8'h01);
    dbRead(8'h05, d);
    check(d, 8'h00);
    check(8'(errCount), 8'h03);
    dbWrite(CTL, 8'h00);
    axiWrite(4'h8, 32'h0, r);
    check({6'h00, r}, {6'h00, `AXI_SLVERR});
    axiRead(4'hc, s);
    check(s[7:0], 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    pageSelTest();
    byteTest();
    rowTest();
    standbyTest();
    dbWrite(CTL, 8'h40);
    repeat (2) @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    check(pageMap, 8'h00);
    check({7'h00, nvmStandby}, 8'h00);
    check({7'h00, nvmBusy}, 8'h00);
    testDone();
  end
  initial begin
    #200000;
    numErrors++;
    testDone();
  end
endmodule
